/* verilog/spbm_regs.vh */
`ifndef SPBM_REGS_VH
`define SPBM_REGS_VH
// ----------------------------------------
// bus register byte offsets
// ----------------------------------------
`define SPBM_OFF_CMD 12'h000
`define SPBM_OFF_RDATA 12'h004
`define SPBM_OFF_CFG 12'h008
`define SPBM_OFF_STATUS 12'h00C
`define SPBM_OFF_LINES 12'h010
`define SPBM_OFF_CTRL 12'h014
`define SPBM_OFF_LDREG 12'h018
// ----------------------------------------
// command word fields
// ----------------------------------------
`define SPBM_CMD_ADDR_LSB 0
`define SPBM_CMD_ADDR_MSB 11
`define SPBM_CMD_WR_BIT 12
`define SPBM_CMD_DATA_BIT 13
// ----------------------------------------
// bit displacement map, controller half
// ----------------------------------------
`define SPBM_D_ZERO8 5'h08
`define SPBM_D_ERR 5'h09
`define SPBM_D_PERR 5'h0A
`define SPBM_D_OERR 5'h0B
`define SPBM_D_FERR 5'h0C
`define SPBM_D_FULL 5'h0D
`define SPBM_D_START 5'h0E
`define SPBM_D_TEST 5'h0F
`define SPBM_D_RTS 5'h10
`define SPBM_D_BRK 5'h11
`define SPBM_D_IEN0 5'h12
`define SPBM_D_IEN3 5'h15
`define SPBM_D_RESET 5'h1F
`define SPBM_REGDATA_W 11
// ----------------------------------------
// reset values
// ----------------------------------------
`define SPBM_SEL_RESET 4'hF
`endif

/* verilog/spbm_fifo.v */
`timescale 1ns/1ns
`default_nettype none
module spbm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL_COUNT = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg out_valid_reg;
  wire push;
  wire pop;
  wire load;

  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign in_ready = (count_reg != FULL_COUNT);
  assign push = in_valid && in_ready;
  // output register refills when count_reg is nonzero and the register is empty or being taken
  assign load = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready);
  assign pop = out_valid_reg && out_ready;
  assign out_valid = out_valid_reg;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid_reg <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (load) begin
        out_data <= mem[rd_ptr_reg[AW-1:0]];
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_valid_reg <= 1'b1;
      end else if (pop) begin
        out_valid_reg <= 1'b0;
      end
      if (push && !load) begin
        count_reg <= count_reg + 1'b1;
      end else if (!push && load) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/spbm_sync.v */
`timescale 1ns/1ns
`default_nettype none
module spbm_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire arst_n,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_reg;

  // first stage is read only by the second
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* verilog/spbm_port.v */
// Contract
// - a9..a14 give bit displacement from base
// - read 0-7 data, 8 zero, 9-12 errors
// - writes 0-10 load selected register data
// - 11-14 select loads, 15 test, 31 reset
// - write 16 rts, 17 break
// - writes 18-21 set interrupt enables
// - read interrupts at 16,17,19,20,31; 18 zero
// - read 21-25 buffer and timer status
// - read 26-30 rts, dtr, cts, change, flag
// - aux groups read dtr,dsr,ri; write dtr
// - aux positions 4,5 switches; 4-7 led
// - switches read only for addressed port
// - autocall writes digit, strobe, request, led
// - autocall reads dialer status lines
// - a9 selects controller or auxiliary half
`timescale 1ns/1ns
`default_nettype none
`include "spbm_regs.vh"
module spbm_port #(
  parameter AUTOCALL = 1,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk,
  input wire arst_n,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hsel,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire [5:0] port_switch,
  input wire [1:0] level_switch,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  input wire [3:0] rx_errs,
  input wire rx_full_bit,
  input wire rx_start_bit,
  input wire serial_in_pin,
  input wire [4:0] irq_state,
  input wire [4:0] ctl_status,
  input wire cts_in,
  input wire line_changed,
  input wire load_break_flag,
  input wire dsr_in,
  input wire ri_in,
  input wire [4:0] dialer_in,
  output reg [`SPBM_REGDATA_W-1:0] reg_load_data,
  output reg reg_load_stb,
  output reg [3:0] load_select,
  output reg loopback_test,
  output reg rts_drive_on,
  output reg break_drive_on,
  output reg [3:0] irq_en,
  output reg ctl_reset,
  output reg dtr_out,
  output reg led_out,
  output reg [3:0] dial_digit,
  output reg digit_present,
  output reg call_request,
  output reg autocall_led
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [11:0] pins_s;
  wire [5:0] sw_s;
  wire [1:0] lvl_s;
  wire [4:0] dial_s;
  wire pin_s;
  wire cts_s;
  wire dsr_s;
  wire ri_s;
  spbm_sync #(.WIDTH(12)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({port_switch, level_switch, serial_in_pin, cts_in, dsr_in, ri_in}),
    .q(pins_s)
  );
  spbm_sync #(.WIDTH(5)) u_sync_dial (
    .clk(clk),
    .arst_n(arst_n),
    .d(dialer_in),
    .q(dial_s)
  );
  assign sw_s = pins_s[11:6];
  assign lvl_s = pins_s[5:4];
  assign pin_s = pins_s[3];
  assign cts_s = pins_s[2];
  assign dsr_s = pins_s[1];
  assign ri_s = pins_s[0];

  // ----------------------------------------
  // receive fifo
  // ----------------------------------------
  wire fifo_valid;
  wire [7:0] fifo_data;
  reg fifo_pop;
  spbm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------
  // ahb-lite slave, zero wait
  // ----------------------------------------
  reg ph_valid_reg;
  reg ph_write_reg;
  reg [11:0] ph_addr_reg;
  reg [31:0] cmd_reg;
  reg busy_reg;
  reg bit_rd_reg;
  wire take;
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= 12'h000;
    end else if (hready) begin
      ph_valid_reg <= take;
      ph_write_reg <= hwrite;
      ph_addr_reg <= haddr[11:0];
    end
  end

  wire wr_en;
  wire rd_en;
  assign wr_en = ph_valid_reg && ph_write_reg;
  assign rd_en = take && !hwrite;

  // ----------------------------------------
  // bit access decode
  // ----------------------------------------
  wire [11:0] bit_addr;
  wire [4:0] disp;
  wire aux_half;
  wire hit;
  wire go_cmd;
  wire go_wr;
  wire go_val;
  assign go_cmd = wr_en && (ph_addr_reg == `SPBM_OFF_CMD);
  assign bit_addr = hwdata[`SPBM_CMD_ADDR_MSB:`SPBM_CMD_ADDR_LSB];
  assign go_wr = hwdata[`SPBM_CMD_WR_BIT];
  assign go_val = hwdata[`SPBM_CMD_DATA_BIT];
  assign hit = (bit_addr[11:6] == sw_s);
  assign aux_half = bit_addr[5];
  assign disp = bit_addr[4:0];

  wire [2:0] pos;
  assign pos = disp[2:0];

  // read mux
  reg rbit;
  always @* begin
    rbit = 1'b0;
    if (!aux_half) begin
      if (disp < 5'h08) begin
        rbit = fifo_data[disp[2:0]];
      end else begin
        case (disp)
          `SPBM_D_ZERO8: rbit = 1'b0;
          `SPBM_D_ERR: rbit = rx_errs[3];
          `SPBM_D_PERR: rbit = rx_errs[2];
          `SPBM_D_OERR: rbit = rx_errs[1];
          `SPBM_D_FERR: rbit = rx_errs[0];
          `SPBM_D_FULL: rbit = rx_full_bit;
          `SPBM_D_START: rbit = rx_start_bit;
          `SPBM_D_TEST: rbit = pin_s;
          5'h10: rbit = irq_state[4];
          5'h11: rbit = irq_state[3];
          5'h12: rbit = 1'b0;
          5'h13: rbit = irq_state[2];
          5'h14: rbit = irq_state[1];
          5'h15: rbit = fifo_valid;
          5'h16: rbit = ctl_status[4];
          5'h17: rbit = ctl_status[3];
          5'h18: rbit = ctl_status[2];
          5'h19: rbit = ctl_status[1];
          5'h1A: rbit = rts_drive_on;
          5'h1B: rbit = dtr_out;
          5'h1C: rbit = cts_s;
          5'h1D: rbit = line_changed;
          5'h1E: rbit = load_break_flag;
          5'h1F: rbit = irq_state[0];
          default: rbit = 1'b0;
        endcase
      end
    end else if (AUTOCALL != 0 && disp[4]) begin
      // upper auxiliary area of the autocall port
      if (pos < 3'd5) begin
        rbit = dial_s[3'd4 - pos];
      end
    end else begin
      case (pos)
        3'd0: rbit = dtr_out;
        3'd1: rbit = dsr_s;
        3'd2: rbit = ri_s;
        3'd4: rbit = lvl_s[0];
        3'd5: rbit = lvl_s[1];
        default: rbit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // controller and auxiliary outputs
  // ----------------------------------------
  reg [`SPBM_REGDATA_W-1:0] shadow_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
      bit_rd_reg <= 1'b0;
      fifo_pop <= 1'b0;
      shadow_reg <= {`SPBM_REGDATA_W{1'b0}};
      reg_load_data <= {`SPBM_REGDATA_W{1'b0}};
      reg_load_stb <= 1'b0;
      load_select <= `SPBM_SEL_RESET;
      loopback_test <= 1'b0;
      rts_drive_on <= 1'b0;
      break_drive_on <= 1'b0;
      irq_en <= 4'h0;
      ctl_reset <= 1'b0;
      dtr_out <= 1'b0;
      led_out <= 1'b0;
      dial_digit <= 4'h0;
      digit_present <= 1'b0;
      call_request <= 1'b0;
      autocall_led <= 1'b0;
    end else begin
      reg_load_stb <= 1'b0;
      ctl_reset <= 1'b0;
      fifo_pop <= 1'b0;
      if (go_cmd) begin
        cmd_reg <= hwdata;
        busy_reg <= 1'b0;
        if (hit && !go_wr) begin
          bit_rd_reg <= rbit;
        end
        if (hit && go_wr && !aux_half) begin
          if (disp <= 5'h0A) begin
            // register bits accumulate; strobe on every bit so the controller tracks
            shadow_reg[disp[3:0]] <= go_val;
            reg_load_data <= shadow_reg;
            reg_load_data[disp[3:0]] <= go_val;
            reg_load_stb <= 1'b1;
          end else if (disp <= `SPBM_D_START) begin
            load_select[disp[1:0] + 2'd1] <= go_val;
          end else if (disp == `SPBM_D_TEST) begin
            loopback_test <= go_val;
          end else if (disp == `SPBM_D_RTS) begin
            rts_drive_on <= go_val;
          end else if (disp == `SPBM_D_BRK) begin
            break_drive_on <= go_val;
          end else if (disp >= `SPBM_D_IEN0 && disp <= `SPBM_D_IEN3) begin
            irq_en[disp[1:0] + 2'd2] <= go_val;
            if (disp == `SPBM_D_IEN0) begin
              fifo_pop <= fifo_valid; // loaded flag clears by taking the char
            end
          end else if (disp == `SPBM_D_RESET && go_val) begin
            ctl_reset <= 1'b1;
            load_select <= `SPBM_SEL_RESET;
          end
        end
        if (hit && go_wr && aux_half) begin
          if (AUTOCALL != 0 && disp[4]) begin
            case (pos)
              3'd0: dial_digit[0] <= go_val;
              3'd1: dial_digit[1] <= go_val;
              3'd2: dial_digit[2] <= go_val;
              3'd3: dial_digit[3] <= go_val;
              3'd4: digit_present <= go_val;
              3'd5: call_request <= go_val;
              3'd6: autocall_led <= go_val;
              default: ;
            endcase
          end else if (pos < 3'd4) begin
            dtr_out <= go_val;
          end else begin
            led_out <= go_val;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (haddr[11:0])
        `SPBM_OFF_CMD: hrdata <= cmd_reg;
        `SPBM_OFF_RDATA: hrdata <= {31'h0000_0000, bit_rd_reg};
        `SPBM_OFF_CFG: hrdata <= {26'h000_0000, sw_s};
        `SPBM_OFF_STATUS: hrdata <= {23'h00_0000, fifo_valid, fifo_data};
        `SPBM_OFF_LINES: hrdata <= {27'h000_0000, dial_s};
        `SPBM_OFF_CTRL: hrdata <= {22'h00_0000, irq_en, load_select, loopback_test, busy_reg};
        `SPBM_OFF_LDREG: hrdata <= {21'h00_0000, shadow_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* sim/spbm_props.sv */
`timescale 1ns/1ns
`default_nettype none
module spbm_props #(
  parameter AUTOCALL = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [5:0] port_switch,
  input wire logic rx_ready,
  input wire logic [10:0] reg_load_data,
  input wire logic reg_load_stb,
  input wire logic [3:0] load_select,
  input wire logic loopback_test,
  input wire logic rts_drive_on,
  input wire logic break_drive_on,
  input wire logic [3:0] irq_en,
  input wire logic ctl_reset,
  input wire logic dtr_out,
  input wire logic led_out,
  input wire logic [3:0] dial_digit
);
  // ----------------------------------------
  // bit write decode, one cycle after the data phase
  // ----------------------------------------
  logic ph;
  logic hit;
  logic fg;
  logic [5:0] b;
  logic d;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph <= 1'b0;
      hit <= 1'b0;
      fg <= 1'b0;
      b <= 6'h00;
      d <= 1'b0;
    end else begin
      ph <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == 12'h000;
      hit <= ph && hwdata[12] && hwdata[11:6] == port_switch;
      fg <= ph && hwdata[12] && hwdata[11:6] != port_switch;
      b <= hwdata[5:0];
      d <= hwdata[13];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero wait okay");
  sel_load_a: assert property (hit && b >= 11 && b <= 14 |-> load_select[b - 11] == d)
    else $error("load select bit wrong");
  test_mode_a: assert property (hit && b == 15 |-> loopback_test == d)
    else $error("test mode wrong");
  ctl_reset_a: assert property (hit && b == 31 && d |-> ctl_reset && load_select == 4'hF ##1 !ctl_reset)
    else $error("controller reset pulse wrong");
  reg_data_a: assert property (hit && b <= 10 |-> reg_load_stb && reg_load_data[b] == d ##1 !reg_load_stb)
    else $error("register data strobe wrong");
  rts_brk_a: assert property (hit && (b == 16 || b == 17) |-> (b == 16 ? rts_drive_on : break_drive_on) == d)
    else $error("rts or break wrong");
  irq_en_a: assert property (hit && b >= 18 && b <= 21 |-> irq_en[b - 18] == d)
    else $error("interrupt enable wrong");
  aux_dtr_a: assert property (hit && b[5:4] == 2'b10 && b[2:0] == 3'h0 |-> dtr_out == d)
    else $error("dtr wrong");
  port_led_a: assert property (hit && b[5:4] == 2'b10 && b[2:0] == 3'h4 |-> led_out == d)
    else $error("port led wrong");
  dial_digit_a: assert property (hit && AUTOCALL != 0 && b[5:4] == 2'b11 && !b[2] |-> dial_digit[b[1:0]] == d)
    else $error("dial digit wrong");
  foreign_ign_a: assert property (fg |-> $stable(rts_drive_on) && $stable(dtr_out) && !reg_load_stb)
    else $error("foreign port write acted");
  cover property (hit && b == 31 && d);
  cover property (fg);
  cover property (!rx_ready);
endmodule
bind spbm_port spbm_props #(.AUTOCALL(AUTOCALL)) spbm_props_i (.*);
`default_nettype wire

/* sim/spbm_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module spbm_ctl_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic push,
  input wire logic [7:0] pdata,
  input wire logic slow,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  // ----------------------------------------
  // received character source
  // ----------------------------------------
  logic [7:0] q[$];
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q.delete();
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      if (push)
        q.push_back(pdata);
      if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
        // released lines must not keep showing the old char
        rx_data <= ~rx_data;
      end else if (!rx_valid && q.size() > 0 && !slow) begin
        rx_data <= q.pop_front();
        rx_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/spbm_port_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spbm_regs.vh"
module spbm_port_tb_top;
  // ----------------------------------------
  // stimulus and checks
  // ----------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [5:0] port_switch = 6'h00;
  logic [1:0] level_switch = 2'h0;
  logic [3:0] rx_errs = 4'h0;
  logic rx_full_bit = 1'b0, rx_start_bit = 1'b0, serial_in_pin = 1'b0, cts_in = 1'b0;
  logic line_changed = 1'b0, load_break_flag = 1'b0, dsr_in = 1'b0, ri_in = 1'b0;
  logic push = 1'b0, slow = 1'b0;
  logic [4:0] irq_state = 5'h00, ctl_status = 5'h00, dialer_in = 5'h00;
  logic [7:0] pdata = 8'h00;
  wire [31:0] hrdata;
  wire [10:0] reg_load_data;
  wire [7:0] rx_data;
  wire [3:0] load_select, irq_en, dial_digit;
  wire hready, hreadyout, hresp, rx_ready, rx_valid, reg_load_stb, loopback_test, rts_drive_on;
  wire break_drive_on, ctl_reset, dtr_out, led_out, digit_present, call_request, autocall_led;
  logic [15:0] rnd = 16'h0023;
  int n_errors = 0;
  int checked = 0;
  logic rts_m = 1'b0, dtr_m = 1'b0, v;
  logic [31:0] r;
  logic [7:0] c;
  logic [7:0] exp_q[$];
  assign hready = hreadyout;
  spbm_port #(.AUTOCALL(1), .FIFO_DEPTH(8), .FIFO_AW(3)) spbm_port_i (.*);
  spbm_ctl_model spbm_ctl_model_i (.clk(clk), .arst_n(arst_n), .push(push), .pdata(pdata), .slow(slow),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
  initial begin
    forever #5 clk = ~clk;
  end
  function logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int j;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      j = 0;
      do begin
        @(posedge clk);
        j++;
      end while (hready !== 1'b1 && j < 40);
      if (j >= 40) begin
        n_errors++;
        finish_test;
      end
      if (k == 0) begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
      end
    end
    r = hrdata;
  endtask
  task bit_wr(input logic [5:0] d, input logic x);
    bus(1'b1, {20'h0_0000, `SPBM_OFF_CMD}, {18'h0_0000, x, 1'b1, port_switch, d});
    #1;
  endtask
  task bit_rd(input logic [5:0] d);
    bus(1'b1, {20'h0_0000, `SPBM_OFF_CMD}, {18'h0_0000, 2'b00, port_switch, d});
    bus(1'b0, {20'h0_0000, `SPBM_OFF_RDATA}, 32'h0000_0000);
    v = r[0];
  endtask
  function logic exp_bit(input int d);
    logic [7:0] hd;
    hd = exp_q.size() > 0 ? exp_q[0] : 8'h00;
    if (d < 8)
      return hd[d];
    if (d >= 9 && d <= 12)
      return rx_errs[12 - d];
    if (d >= 22 && d <= 25)
      return ctl_status[26 - d];
    if (d >= 48)
      return d % 8 < 5 ? dialer_in[4 - d % 8] : 1'b0;
    case (d)
      13: return rx_full_bit;
      14: return rx_start_bit;
      15: return serial_in_pin;
      16: return irq_state[4];
      17: return irq_state[3];
      19: return irq_state[2];
      20: return irq_state[1];
      21: return exp_q.size() > 0;
      26: return rts_m;
      27: return dtr_m;
      28: return cts_in;
      29: return line_changed;
      30: return load_break_flag;
      31: return irq_state[0];
      32, 40: return dtr_m;
      33, 41: return dsr_in;
      34, 42: return ri_in;
      36, 44: return level_switch[0];
      37, 45: return level_switch[1];
      default: return 1'b0;
    endcase
  endfunction
  function logic out_bit(input int d);
    case (d)
      11, 12, 13, 14: return load_select[d - 11];
      15: return loopback_test;
      16: return rts_drive_on;
      17: return break_drive_on;
      18, 19, 20, 21: return irq_en[d - 18];
      32, 40: return dtr_out;
      36, 44: return led_out;
      52, 60: return digit_present;
      53, 61: return call_request;
      54, 62: return autocall_led;
      default: return dial_digit[d % 4];
    endcase
  endfunction
  initial begin
    rnd = lfsr(rnd);
    port_switch <= rnd[5:0];
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({load_select, rts_drive_on, dtr_out, irq_en}, 10'h3C0);
    for (int i = 0; i < 11; i++) begin
      rnd = lfsr(rnd);
      bit_wr(i[5:0], rnd[0]);
      chk(reg_load_data[i], rnd[0]);
    end
    bit_wr(6'h1F, 1'b1);
    chk(load_select, 4'hF);
    for (int n = 0; n < 2; n++) begin
      rnd = lfsr(rnd);
      {rx_errs, rx_full_bit, rx_start_bit, serial_in_pin, cts_in, line_changed, load_break_flag} <= rnd[9:0];
      {dsr_in, ri_in, level_switch} <= rnd[13:10];
      rnd = lfsr(rnd);
      {irq_state, ctl_status, dialer_in} <= rnd[14:0];
      for (int d = 11; d < 64; d++) begin
        if ((d <= 21) || d == 32 || d == 36 || d == 40 || d == 44 || (d >= 48 && d % 8 != 7)) begin
          rnd = lfsr(rnd);
          bit_wr(d[5:0], rnd[0]);
          chk(out_bit(d), rnd[0]);
          if (d == 16)
            rts_m = rnd[0];
          if (d == 32 || d == 40)
            dtr_m = rnd[0];
          if (d == 18 && exp_q.size() > 0)
            void'(exp_q.pop_front());
        end
      end
      bus(1'b1, {20'h0_0000, `SPBM_OFF_CMD}, {18'h0_0000, ~rts_m, 1'b1, port_switch ^ 6'h01, 6'h10});
      #1;
      chk(rts_drive_on, rts_m);
      rnd = lfsr(rnd);
      pdata <= rnd[7:0];
      push <= 1'b1;
      exp_q.push_back(rnd[7:0]);
      @(posedge clk);
      push <= 1'b0;
      repeat (5) @(posedge clk);
      for (int d = 0; d < 64; d++) begin
        bit_rd(d[5:0]);
        chk(v, exp_bit(d));
      end
    end
    bit_wr(6'h12, 1'b0);
    void'(exp_q.pop_front());
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      pdata <= rnd[7:0];
      slow <= rnd[8];
      push <= 1'b1;
      exp_q.push_back(rnd[7:0]);
      @(posedge clk);
    end
    push <= 1'b0;
    slow <= 1'b0;
    for (int j = 0; j < 60 && rx_ready !== 1'b0; j++)
      @(posedge clk);
    chk({rx_ready, rx_valid}, 2'b00);
    for (int i = 0; i < 9; i++) begin
      bit_rd(6'h15);
      chk(v, 1'b1);
      for (int b = 0; b < 8; b++) begin
        bit_rd(b[5:0]);
        c[b] = v;
      end
      chk(c, exp_q.pop_front());
      bit_wr(6'h12, 1'b0);
    end
    bit_rd(6'h15);
    chk(v, 1'b0);
    finish_test;
  end
endmodule
`default_nettype wire
